// *** prs_sequencer.sv ***
// Summary of operation
// - After power-up the active-low system reset output stays low until the reset delay has run out.
// - The reset delay ends after a fixed count of clock cycles standing in for the charging capacitor.
// - A supply drop seen on the supply trip input drives the system reset output low three clock cycles later.
// - If the supply returns during a retract, the retract finishes, then the delay runs, reset low throughout.
// - The parking configuration bits are not cleared by the system reset and keep their values.
// - Every other writable bit is held at its reset value while the system reset output is low.
// - While the system reset is low the spindle is braked with all low sides on, except during retract.
// - On a supply drop with the spindle spinning, the spindle outputs tristate as the reset falls.
// - At that same moment the actuator retract starts with the programmed duration and voltage.
// - When the retract duration has elapsed the spindle outputs go from tristate to brake.
`timescale 1ns/1ps
module prs_sequencer
  import prs_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES   = POR_DELAY_CYCLES,
  parameter int unsigned RETRACT_CYCLES = RETRACT_UNIT_CYCLES
)
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Supply monitor
  input  wire logic        i_supply_trip_input,
  // Reset and power stage control
  output logic             o_system_reset_out_n,
  output logic             o_spindle_brake,
  output logic             o_spindle_tristate,
  output logic             o_retract_active,
  output logic [1:0]       o_retract_voltage
);
  import prs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  prs_state_t        state_reg;
  prs_state_t        state_next;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [PARK_W-1:0] park_reg;
  logic              supply_ok;
  logic              delay_start;
  logic              delay_expired;
  logic              retract_start;
  logic              retract_expired;
  logic [TMR_W-1:0]  retract_limit;
  logic              acc;
  logic              wr;
  logic              mapped;
  logic              ctrl_wr;
  logic              park_wr;
  logic              spinning;
  logic [TMR_W-1:0]  dly_cnt_reg;
  logic [TMR_W-1:0]  rtr_cnt_reg;
  logic [TMR_W-1:0]  retract_len_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Supply monitor input
  prs_sync2 u_sync_supply
  (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   (i_supply_trip_input),
    .o_sync    (supply_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Timers
  assign delay_start   = (state_next == ST_DELAY) && (state_reg != ST_DELAY);
  assign retract_start = (state_next == ST_RETRACT) && (state_reg != ST_RETRACT);
  assign retract_limit = TMR_W'(RETRACT_CYCLES) * TMR_W'({30'h0, park_reg[PARK_TIME +: 2]} + 32'h1);

  prs_timer u_delay_timer
  (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_start   (delay_start),
    .i_limit   (TMR_W'(DELAY_CYCLES)),
    .o_expired (delay_expired)
  );

  prs_timer u_retract_timer
  (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_start   (retract_start),
    .i_limit   (retract_limit),
    .o_expired (retract_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  assign spinning = ctrl_reg[CTRL_SPIN];

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_BRAKE:
        if (supply_ok)
          state_next = ST_DELAY;
      ST_DELAY:
        if (!supply_ok)
          state_next = ST_BRAKE;
        else if (delay_expired && !delay_start)
          state_next = ST_RUN;
      ST_RUN:
        if (!supply_ok)
          state_next = spinning ? ST_RETRACT : ST_BRAKE;
      ST_RETRACT:
        if (retract_expired && !retract_start)
          state_next = supply_ok ? ST_DELAY : ST_BRAKE;
      default:
        state_next = ST_BRAKE;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      state_reg <= ST_BRAKE;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power stage outputs
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_system_reset_out_n <= 1'h0;
      o_spindle_brake      <= 1'h1;
      o_spindle_tristate   <= 1'h0;
      o_retract_active     <= 1'h0;
      o_retract_voltage    <= 2'h0;
    end
    else
    begin
      o_system_reset_out_n <= (state_next == ST_RUN);
      o_spindle_brake      <= (state_next == ST_DELAY) || (state_next == ST_BRAKE);
      o_spindle_tristate   <= (state_next == ST_RETRACT);
      o_retract_active     <= (state_next == ST_RETRACT);
      o_retract_voltage    <= park_reg[PARK_VOLT +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign mapped  = (paddr == CTRL_OFS) || (paddr == PARK_OFS) || (paddr == STATUS_OFS);
  assign ctrl_wr = wr && (paddr == CTRL_OFS);
  assign park_wr = wr && (paddr == PARK_OFS);
  assign pready  = 1'h1;
  assign pslverr = acc && !mapped;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        CTRL_OFS:   prdata <= {{(32-CTRL_W){1'h0}}, ctrl_reg};
        PARK_OFS:   prdata <= {{(32-PARK_W){1'h0}}, park_reg};
        STATUS_OFS: prdata <= {26'h0, supply_ok, o_system_reset_out_n, state_reg};
        default:    prdata <= 32'h0;
      endcase
    end
  end

  // Control bits held at reset value while system reset is low
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || !o_system_reset_out_n)
      ctrl_reg <= CTRL_RST;
    else if (ctrl_wr)
      ctrl_reg <= pwdata[CTRL_W-1:0];
  end

  // Parking bits cleared only by the logic reset, never by system reset
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      park_reg <= PARK_RST;
    else if (park_wr)
      park_reg <= pwdata[PARK_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counters watched by the timing assertions
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || (state_reg != ST_DELAY))
      dly_cnt_reg <= '0;
    else
      dly_cnt_reg <= dly_cnt_reg + 1'h1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || (state_reg != ST_RETRACT))
      rtr_cnt_reg <= '0;
    else
      rtr_cnt_reg <= rtr_cnt_reg + 1'h1;
  end

  // Length loaded into the retract timer, kept for the whole retract
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      retract_len_reg <= '0;
    else if (retract_start)
      retract_len_reg <= retract_limit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_onehot_state;
    @(posedge i_clk_sys) disable iff (i_rst)
    $onehot(state_reg);
  endproperty
  a_onehot_state: assert property (p_onehot_state)
    else $error("sequencer state not one-hot");

  property p_release_after_delay;
    @(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_system_reset_out_n) |-> $past(state_reg) == ST_DELAY && $past(delay_expired) && $past(supply_ok);
  endproperty
  a_release_after_delay: assert property (p_release_after_delay)
    else $error("reset released without completed delay");

  property p_delay_to_run;
    @(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == ST_DELAY && delay_expired && supply_ok) |=> state_reg == ST_RUN ##0 o_system_reset_out_n;
  endproperty
  a_delay_to_run: assert property (p_delay_to_run)
    else $error("delay expiry did not release reset");

  property p_drop_asserts_reset;
    @(posedge i_clk_sys) disable iff (i_rst)
    !supply_ok |=> !o_system_reset_out_n;
  endproperty
  a_drop_asserts_reset: assert property (p_drop_asserts_reset)
    else $error("reset not asserted on supply drop");

  property p_retract_holds_reset;
    @(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == ST_RETRACT && supply_ok && retract_expired) |=> state_reg == ST_DELAY ##1 !o_system_reset_out_n;
  endproperty
  a_retract_holds_reset: assert property (p_retract_holds_reset)
    else $error("retract with supply back did not go to delay");

  property p_park_kept;
    @(posedge i_clk_sys) disable iff (i_rst)
    !park_wr |=> park_reg == $past(park_reg);
  endproperty
  a_park_kept: assert property (p_park_kept)
    else $error("parking bits changed without a write");

  property p_ctrl_held;
    @(posedge i_clk_sys) disable iff (i_rst)
    !o_system_reset_out_n |=> ctrl_reg == CTRL_RST;
  endproperty
  a_ctrl_held: assert property (p_ctrl_held)
    else $error("control bits not held in reset");

  property p_brake_in_reset;
    @(posedge i_clk_sys) disable iff (i_rst)
    (!o_system_reset_out_n && !o_retract_active) |-> o_spindle_brake && !o_spindle_tristate;
  endproperty
  a_brake_in_reset: assert property (p_brake_in_reset)
    else $error("spindle not braked during reset");

  property p_drop_while_spinning;
    @(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == ST_RUN && !supply_ok && spinning)
      |=> o_spindle_tristate && !o_spindle_brake && $fell(o_system_reset_out_n);
  endproperty
  a_drop_while_spinning: assert property (p_drop_while_spinning)
    else $error("spindle not tristated at reset fall");

  property p_retract_start;
    @(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == ST_RUN && !supply_ok && spinning)
      |=> o_retract_active && o_retract_voltage == $past(park_reg[PARK_VOLT +: 2]);
  endproperty
  a_retract_start: assert property (p_retract_start)
    else $error("retract not started with programmed voltage");

  property p_retract_end_brake;
    @(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == ST_RETRACT && retract_expired && !retract_start)
      |=> o_spindle_brake && !o_spindle_tristate && !o_retract_active;
  endproperty
  a_retract_end_brake: assert property (p_retract_end_brake)
    else $error("spindle not braked after retract");

  property p_delay_len;
    @(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_system_reset_out_n) |-> dly_cnt_reg == DELAY_CYCLES + 1;
  endproperty
  a_delay_len: assert property (p_delay_len)
    else $error("reset delay length wrong");

  property p_retract_len;
    @(posedge i_clk_sys) disable iff (i_rst)
    $fell(o_retract_active) |-> rtr_cnt_reg == retract_len_reg + 1'h1;
  endproperty
  a_retract_len: assert property (p_retract_len)
    else $error("retract length wrong");

  property p_retract_ignores_supply;
    @(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == ST_RETRACT && !retract_expired) |=> state_reg == ST_RETRACT && !o_system_reset_out_n;
  endproperty
  a_retract_ignores_supply: assert property (p_retract_ignores_supply)
    else $error("retract cut short");

  property p_brake_to_delay;
    @(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == ST_BRAKE && supply_ok) |=> state_reg == ST_DELAY && !o_system_reset_out_n;
  endproperty
  a_brake_to_delay: assert property (p_brake_to_delay)
    else $error("supply return did not start the delay");

  property p_idle_drop_brake;
    @(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == ST_RUN && !supply_ok && !spinning)
      |=> o_spindle_brake && !o_spindle_tristate && !o_retract_active;
  endproperty
  a_idle_drop_brake: assert property (p_idle_drop_brake)
    else $error("idle spindle not braked on supply drop");

  property p_run_released;
    @(posedge i_clk_sys) disable iff (i_rst)
    o_system_reset_out_n |-> !o_spindle_brake && !o_spindle_tristate && !o_retract_active;
  endproperty
  a_run_released: assert property (p_run_released)
    else $error("power stage not released while out of reset");

endmodule // prs_sequencer

// *** prs_pkg.sv ***
package prs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_HZ               = 125_000_000;
  localparam int unsigned POR_DELAY_MS         = 150;
  localparam int unsigned POR_DELAY_CYCLES     = POR_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned RETRACT_UNIT_US      = 10_000;
  localparam int unsigned RETRACT_UNIT_CYCLES  = RETRACT_UNIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TMR_W                = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] PARK_OFS   = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;

  localparam int unsigned CTRL_W     = 1;
  localparam int unsigned CTRL_SPIN  = 0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 1'h0;

  localparam int unsigned PARK_W     = 6;
  localparam int unsigned PARK_VOLT  = 0;
  localparam int unsigned PARK_TIME  = 2;
  localparam int unsigned PARK_SPARE = 4;
  localparam int unsigned PARK_UNUSE = 5;
  localparam logic [PARK_W-1:0] PARK_RST = 6'h00;

  localparam int unsigned STAT_STATE = 0;
  localparam int unsigned STAT_RSTN  = 4;
  localparam int unsigned STAT_SUPOK = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [3:0] {
    ST_DELAY   = 4'h1,
    ST_RUN     = 4'h2,
    ST_RETRACT = 4'h4,
    ST_BRAKE   = 4'h8
  } prs_state_t;

endpackage

// *** prs_sync2.sv ***
`timescale 1ns/1ps
module prs_sync2
(
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // Level
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_reg;

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      meta_reg <= 1'h0;
      o_sync   <= 1'h0;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule // prs_sync2

// *** prs_timer.sv ***
`timescale 1ns/1ps
module prs_timer
  import prs_pkg::*;
(
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  // Control
  input  wire logic             i_start,
  input  wire logic [TMR_W-1:0] i_limit,
  output logic                  o_expired
);
  logic [TMR_W-1:0] cnt_reg;

  // Loads the limit and counts down to zero
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      cnt_reg <= '0;
    else if (i_start)
      cnt_reg <= i_limit;
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - 1'h1;
  end

  assign o_expired = (cnt_reg == '0);
endmodule // prs_timer

// *** prs_ctrl_model.sv ***
`timescale 1ns/1ps
module prs_ctrl_model
(
  // Clock
  input  wire logic        i_clk_sys,
  // APB master
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [11:0]      o_paddr,
  output logic [31:0]      o_pwdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr
);
  initial
  begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 12'h000;
    o_pwdata  = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One transfer: setup, then access held until pready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge i_clk_sys);
    o_psel   <= 1'b1;
    o_pwrite <= wr;
    o_paddr  <= a;
    o_pwdata <= d;
    @(posedge i_clk_sys);
    o_penable <= 1'b1;
    @(posedge i_clk_sys);
    while (i_pready !== 1'h1)
      @(posedge i_clk_sys);
    rd = i_prdata;
    err = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
  endtask
endmodule // prs_ctrl_model

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import prs_pkg::*;
  localparam int unsigned DLY = 20;
  localparam int unsigned RTC = 10;
  logic        i_clk_sys;
  logic        i_rst;
  logic        i_supply_trip_input;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        o_system_reset_out_n;
  logic        o_spindle_brake;
  logic        o_spindle_tristate;
  logic        o_retract_active;
  logic [1:0]  o_retract_voltage;
  logic [31:0] rdata;
  logic        rerr;
  logic        seen_hi;
  int          error_cnt;
  int          cmp_count;
  int          n;
  int          cyc;
  int          t0;

  prs_sequencer #(.DELAY_CYCLES(DLY), .RETRACT_CYCLES(RTC)) u_prs_sequencer (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_supply_trip_input(i_supply_trip_input), .o_system_reset_out_n(o_system_reset_out_n),
    .o_spindle_brake(o_spindle_brake), .o_spindle_tristate(o_spindle_tristate),
    .o_retract_active(o_retract_active), .o_retract_voltage(o_retract_voltage));

  prs_ctrl_model u_prs_ctrl_model (
    .i_clk_sys(i_clk_sys), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic rd(input logic [11:0] a);
    u_prs_ctrl_model.xfer(1'b0, a, 32'h0, rdata, rerr);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_prs_ctrl_model.xfer(1'b1, a, d, rdata, rerr);
  endtask

  task automatic wait_rn(input logic lvl);
    n = 0;
    while (o_system_reset_out_n !== lvl)
    begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial
  begin
    error_cnt = 0;
    cmp_count = 0;
    i_rst = 1'b1;
    i_supply_trip_input = 1'b1;
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t0 = cyc;
    @(posedge i_clk_sys);
    #1;
    chk("rst_n", 32'(o_system_reset_out_n), 32'h0);
    chk("brake", 32'(o_spindle_brake), 32'h1);
    chk("tristate", 32'(o_spindle_tristate), 32'h0);
    wr(CTRL_OFS, 32'h1);
    rd(CTRL_OFS);
    chk("ctrl_held", rdata, 32'h0);
    wr(PARK_OFS, 32'h0000000d);
    wait_rn(1'b1);
    chk("por_rise", 32'(o_system_reset_out_n), 32'h1);
    chk("por_len", 32'(cyc - t0 >= DLY), 32'h1);
    $display("power-up test done");
    wr(CTRL_OFS, 32'h1);
    rd(CTRL_OFS);
    chk("ctrl", rdata, 32'h1);
    rd(STATUS_OFS);
    chk("status_run", rdata, 32'h32);
    rd(12'h00c);
    chk("unmapped_err", 32'(rerr), 32'h1);
    chk("unmapped_data", rdata, 32'h0);
    $display("register test done");
    @(posedge i_clk_sys);
    i_supply_trip_input <= 1'b0;
    wait_rn(1'b0);
    chk("drop_fast", 32'(n <= 5), 32'h1);
    #1;
    chk("tri_drop", 32'(o_spindle_tristate), 32'h1);
    chk("brake_drop", 32'(o_spindle_brake), 32'h0);
    chk("retract_on", 32'(o_retract_active), 32'h1);
    chk("retract_volt", 32'(o_retract_voltage), 32'h1);
    n = 0;
    seen_hi = 1'b0;
    while (o_retract_active === 1'b1 && n < 300)
    begin
      @(posedge i_clk_sys);
      if (n == 9)
        i_supply_trip_input <= 1'b1;
      #1;
      n++;
      if (o_system_reset_out_n !== 1'b0)
        seen_hi = 1'b1;
    end
    chk("retract_len", 32'(n), 32'(RTC * 4 + 1));
    chk("brake_after", 32'(o_spindle_brake), 32'h1);
    chk("tri_after", 32'(o_spindle_tristate), 32'h0);
    chk("rst_low_retract", 32'(seen_hi), 32'h0);
    t0 = cyc;
    wait_rn(1'b1);
    chk("delay_after", 32'(cyc - t0 >= DLY), 32'h1);
    rd(PARK_OFS);
    chk("park_kept", rdata, 32'h0000000d);
    rd(CTRL_OFS);
    chk("ctrl_cleared", rdata, 32'h0);
    $display("retract test done");
    @(posedge i_clk_sys);
    i_supply_trip_input <= 1'b0;
    wait_rn(1'b0);
    #1;
    chk("brake_idle", 32'(o_spindle_brake), 32'h1);
    chk("tri_idle", 32'(o_spindle_tristate), 32'h0);
    chk("no_retract", 32'(o_retract_active), 32'h0);
    rd(STATUS_OFS);
    chk("status_brake", rdata, 32'h08);
    $display("idle drop test done");
    test_done();
  end

  initial
  begin
    repeat (5000) @(posedge i_clk_sys);
    error_cnt++;
    $display("Watchdog expired");
    test_done();
  end
endmodule // testbench
